// ### design/tpio_top.v
`timescale 1ns/100ps
`include "tpio_consts.vh"

// Summary of operation
// - Direction one drives pin from latch
// - Direction zero leaves pin undriven input
// - Data writes always update the latch
// - Output pin ordinary read returns latch
// - Input pin read gives pin; READMODWRITE_ACCESS latch
// - Peripheral drives pin; reads as pin
// - CPU reset clears all direction bits
// - Float bit plus stop/watch floats pins
// - Float bit zero keeps pins in standby
// - Port G pull-up follows pull-up bit
// - Port G low output disconnects pull-up
// - Port F uses bits zero to two
// - Port G uses bits one and two
// - Main oscillator owns F0/F1 when zero
// - Reset enable makes F2 reset input
// - F2 is open drain, never high
// - Sub oscillator owns G1/G2 when zero
// - Buzzer over compare0, pulse over compare1
// - Reset floats all pins, F2 included
module tpio_top (
  // Clock, reset and enable
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  input wire por_active,
  // Avalon-MM slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire readmodwrite_access,
  output wire [31:0] readdata,
  output wire waitrequest,
  // Standby state
  input wire stop_or_watch,
  // Peripheral outputs and enables
  input wire buzzer_output,
  input wire buzzer_oe,
  input wire compare_ch0_output,
  input wire compare_ch0_oe,
  input wire pulse_gen_output,
  input wire pulse_gen_oe,
  input wire compare_ch1_output,
  input wire compare_ch1_oe,
  // Port F pins
  input wire [2:0] portf_in,
  output reg [2:0] portf_out,
  output reg [2:0] portf_oe,
  // Port G pins, index 1 and 2 used
  input wire [2:1] portg_in,
  output reg [2:1] portg_out,
  output reg [2:1] portg_oe,
  output reg [2:1] portg_pullup_on,
  // Internal inputs toward peripherals
  output reg [2:0] portf_internal_in,
  output reg [2:1] portg_internal_in,
  output reg ext_reset_in_n
);

  reg rst_s1;
  reg rst_s2;
  reg ack;
  reg [7:0] read_mux;
  reg [7:0] next_wdata;
  reg [2:0] next_pf_out;
  reg [2:0] next_pf_oe;
  reg [2:1] next_pg_out;
  reg [2:1] next_pg_oe;
  reg [2:1] next_pg_pu;
  wire [63:0] regs;
  wire [7:0] rd_store;
  wire [7:0] portf_output_latch;
  wire [7:0] portf_direction;
  wire [7:0] portg_output_latch;
  wire [7:0] portg_direction;
  wire [7:0] portg_pullup_enable;
  wire [7:0] system_config_one;
  wire main_osc_pin_select;
  wire sub_osc_pin_select;
  wire ext_reset_pin_enable;
  wire standby_pin_float;
  wire floating;
  wire [2:0] pf_pin_view;
  wire [2:1] pg_pin_view;
  wire rd_is_latch_reg;
  wire wr_hit;
  reg rmw_q;
  reg [3:0] addr_q;
  reg [7:0] pin_sample;

  // Reset release through two flip-flops.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // Every access takes two clk_en cycles: request, then acknowledge.
  always @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      ack <= 1'b0;
      rmw_q <= 1'b0;
      addr_q <= 4'h0;
      pin_sample <= 8'h00;
    end else if (clk_en) begin
      ack <= (read || write) && !ack;
      rmw_q <= readmodwrite_access;
      addr_q <= address;
      pin_sample <= read_mux;
    end
  end

  assign waitrequest = (read || write) && !ack;
  // A write lands at the edge where the master sees waitrequest low, not before.
  assign wr_hit = write && ack && address <= `TPIO_ADDR_CONFIG;

  // Unused bits are stored as zero.
  always @* begin
    case (address)
      `TPIO_ADDR_PF_LATCH, `TPIO_ADDR_PF_DIR: next_wdata = writedata[7:0] & `TPIO_PF_MASK;
      `TPIO_ADDR_PG_LATCH, `TPIO_ADDR_PG_DIR,
      `TPIO_ADDR_PG_PULLUP: next_wdata = writedata[7:0] & `TPIO_PG_MASK;
      `TPIO_ADDR_CONFIG: next_wdata = writedata[7:0] & 8'h0f;
      default: next_wdata = 8'h00;
    endcase
  end

  // Latch writes land regardless of direction; the directions reset to zero.
  tpio_regstore u_store (
    .clk(clk),
    .rst_n(rst_s2),
    .clk_en(clk_en),
    .wr_en(wr_hit),
    .wr_idx(address[2:0]),
    .wr_data(next_wdata),
    .rd_idx(address[2:0]),
    .rd_data(rd_store),
    .all_regs(regs)
  );

  assign portf_output_latch = regs[7:0];
  assign portf_direction = regs[15:8];
  assign portg_output_latch = regs[23:16];
  assign portg_direction = regs[31:24];
  assign portg_pullup_enable = regs[39:32];
  assign system_config_one = regs[47:40];
  assign main_osc_pin_select = system_config_one[`TPIO_CFG_MAIN_OSC_SEL];
  assign sub_osc_pin_select = system_config_one[`TPIO_CFG_SUB_OSC_SEL];
  assign ext_reset_pin_enable = system_config_one[`TPIO_CFG_EXT_RST_EN];
  assign standby_pin_float = system_config_one[`TPIO_CFG_STANDBY_FLOAT];
  assign floating = standby_pin_float && stop_or_watch;

  // Pin drive, registered so the outputs are glitch free.
  always @* begin
    next_pf_out = 3'h0;
    next_pf_oe = 3'h0;
    next_pg_out = 2'h0;
    next_pg_oe = 2'h0;
    if (main_osc_pin_select) begin
      next_pf_out[1:0] = portf_output_latch[1:0];
      next_pf_oe[1:0] = portf_direction[1:0];
    end
    if (!ext_reset_pin_enable) begin
      next_pf_out[2] = 1'b0;
      next_pf_oe[2] = portf_direction[2] && !portf_output_latch[2];
    end
    if (sub_osc_pin_select) begin
      if (buzzer_oe) begin
        next_pg_out[1] = buzzer_output;
        next_pg_oe[1] = 1'b1;
      end else if (compare_ch0_oe) begin
        next_pg_out[1] = compare_ch0_output;
        next_pg_oe[1] = 1'b1;
      end else begin
        next_pg_out[1] = portg_output_latch[1];
        next_pg_oe[1] = portg_direction[1];
      end
      if (pulse_gen_oe) begin
        next_pg_out[2] = pulse_gen_output;
        next_pg_oe[2] = 1'b1;
      end else if (compare_ch1_oe) begin
        next_pg_out[2] = compare_ch1_output;
        next_pg_oe[2] = 1'b1;
      end else begin
        next_pg_out[2] = portg_output_latch[2];
        next_pg_oe[2] = portg_direction[2];
      end
    end
    // Pull-up on when enabled and not actively driving low.
    next_pg_pu = portg_pullup_enable[2:1] & ~(next_pg_oe & ~next_pg_out);
    if (floating) begin
      next_pf_oe = 3'h0;
      next_pg_oe = 2'h0;
      next_pg_pu = 2'h0;
    end
  end

  // During reset all pins float, F2 included; nothing pulls F2 low at power-on.
  always @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      portf_out <= 3'h0;
      portf_oe <= 3'h0;
      portg_out <= 2'h0;
      portg_oe <= 2'h0;
      portg_pullup_on <= 2'h0;
      portf_internal_in <= 3'h0;
      portg_internal_in <= 2'h0;
      ext_reset_in_n <= 1'b1;
    end else if (clk_en) begin
      portf_out <= next_pf_out;
      portf_oe <= next_pf_oe;
      portg_out <= next_pg_out;
      portg_oe <= next_pg_oe;
      portg_pullup_on <= next_pg_pu;
      portf_internal_in <= floating ? 3'h0 : portf_in;
      portg_internal_in <= floating ? 2'h0 : portg_in;
      ext_reset_in_n <= ext_reset_pin_enable ? portf_in[2] : 1'b1;
    end
  end

  // Pin levels seen by ordinary reads; floating blocks the inputs.
  assign pf_pin_view = floating ? 3'h0 : portf_in;
  assign pg_pin_view = floating ? 2'h0 : portg_in;

  // Pin value for ordinary reads of input or peripheral-driven pins.
  always @* begin
    case (address)
      `TPIO_ADDR_PF_LATCH: read_mux = {5'h00,
        (portf_direction[2:0] & portf_output_latch[2:0]) |
        (~portf_direction[2:0] & pf_pin_view)};
      `TPIO_ADDR_PG_LATCH: read_mux = {5'h00,
        (portg_direction[2:1] & ~{pulse_gen_oe | compare_ch1_oe, buzzer_oe | compare_ch0_oe}
          & portg_output_latch[2:1]) |
        (~(portg_direction[2:1] & ~{pulse_gen_oe | compare_ch1_oe,
          buzzer_oe | compare_ch0_oe}) & pg_pin_view), 1'b0};
      default: read_mux = 8'h00;
    endcase
  end

  assign rd_is_latch_reg = addr_q == `TPIO_ADDR_PF_LATCH || addr_q == `TPIO_ADDR_PG_LATCH;

  // A read-modify-write read of a data register returns the latch.
  assign readdata = {24'h000000,
    addr_q == `TPIO_ADDR_STATUS ? {6'h00, floating, rst_s2} :
    (rd_is_latch_reg && !rmw_q) ? pin_sample : rd_store};

  // por_active is not used; nothing forces F2 low at power-on.
  wire unused_por;
  assign unused_por = por_active;

endmodule

// ### shared/tpio_consts.vh
`ifndef TPIO_CONSTS_VH
`define TPIO_CONSTS_VH

// Register word addresses on the Avalon-MM word bus.
`define TPIO_ADDR_PF_LATCH 4'h0
`define TPIO_ADDR_PF_DIR 4'h1
`define TPIO_ADDR_PG_LATCH 4'h2
`define TPIO_ADDR_PG_DIR 4'h3
`define TPIO_ADDR_PG_PULLUP 4'h4
`define TPIO_ADDR_CONFIG 4'h5
`define TPIO_ADDR_STATUS 4'h6

// Implemented bit masks per port.
`define TPIO_PF_MASK 8'h07
`define TPIO_PG_MASK 8'h06

// Reset values.
`define TPIO_DIR_RESET 8'h00
`define TPIO_LATCH_RESET 8'h00
`define TPIO_PULLUP_RESET 8'h00
`define TPIO_CONFIG_RESET 8'h00

// Config register field positions.
`define TPIO_CFG_MAIN_OSC_SEL 0
`define TPIO_CFG_SUB_OSC_SEL 1
`define TPIO_CFG_EXT_RST_EN 2
`define TPIO_CFG_STANDBY_FLOAT 3

// Number of register slots held in the register store.
`define TPIO_NUM_REGS 8

`endif

// ### design/tpio_regstore.v
`timescale 1ns/100ps
`include "tpio_consts.vh"

// Small register store with registered read data.
module tpio_regstore (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  input wire clk_en,
  // Write port
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [7:0] wr_data,
  // Read port
  input wire [2:0] rd_idx,
  output reg [7:0] rd_data,
  // Flat view of all entries
  output wire [63:0] all_regs
);

  reg [7:0] mem [0:7];
  genvar g;

  generate
    for (g = 0; g < 8; g = g + 1) begin : g_entry
      localparam [2:0] ENTRY_IDX = g;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem[g] <= 8'h00;
        end else if (clk_en && wr_en && wr_idx == ENTRY_IDX) begin
          mem[g] <= wr_data;
        end
      end
      assign all_regs[g*8 +: 8] = mem[g];
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (clk_en) begin
      rd_data <= mem[rd_idx];
    end
  end

endmodule

// ### verification/tpio_monitor.sv
`timescale 1ns/100ps
module tpio_monitor (
  input wire clk, rst_n, read, write, waitrequest, stop_or_watch,
  input wire buzzer_output, buzzer_oe,
  input wire [3:0] address,
  input wire [31:0] writedata,
  input wire [2:0] portf_out, portf_oe, portf_internal_in,
  input wire [2:1] portg_out, portg_oe, portg_pullup_on, portg_internal_in
);
  logic [3:0] cfg;
  logic [2:0] fdir, flat;
  wire fl = cfg[3] & stop_or_watch;
  // Shadows follow each completed bus write, so pin checks need no internal taps.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= 4'h0;
      fdir <= 3'h0;
      flat <= 3'h0;
    end else if (write && !waitrequest) begin
      if (address == 4'h0) flat <= writedata[2:0];
      if (address == 4'h1) fdir <= writedata[2:0];
      if (address == 4'h5) cfg <= writedata[3:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  chk_reset_float: assert property ($rose(rst_n) |-> !portf_oe && !portg_oe)
    else $error("pin driven in reset");
  chk_open_drain: assert property (!(portf_oe[2] && portf_out[2]))
    else $error("open drain pin driven high");
  chk_standby_float: assert property (fl |=> !portf_oe && !portg_oe &&
    !portf_internal_in && !portg_internal_in)
    else $error("pin not floated in standby");
  chk_f_drive: assert property (cfg[0] && !fl && fdir[0] |=> portf_oe[0] &&
    portf_out[0] == $past(flat[0]))
    else $error("output pin not driven from latch");
  chk_f_input: assert property (!fdir[1] |=> !portf_oe[1])
    else $error("input pin driven");
  chk_osc_owns: assert property (!cfg[0] |=> portf_oe[1:0] == 2'h0)
    else $error("oscillator pin driven by port");
  chk_reset_pin: assert property (cfg[2] |=> !portf_oe[2])
    else $error("reset pin driven by port");
  chk_pullup_low: assert property (portg_oe[1] && !portg_out[1] |-> !portg_pullup_on[1])
    else $error("pull-up on a low output");
  chk_buzzer_wins: assert property (cfg[1] && !fl && buzzer_oe |=> portg_oe[1] &&
    portg_out[1] == $past(buzzer_output))
    else $error("buzzer not on its pin");
  cov_float: cover property (fl);
  cov_buzzer: cover property (cfg[1] && buzzer_oe);
  cov_cfg: cover property (write && !waitrequest && address == 4'h5);
endmodule

bind tpio_top tpio_monitor u_mon (.*);

// ### verification/tpio_board.sv
`timescale 1ns/100ps
// Board: a pull-up on the open drain pin; other undriven lines without a Port G pull-up wander each cycle.
module tpio_board (
  input wire clk,
  input wire [2:0] portf_out, portf_oe, fd, fv,
  input wire [2:1] portg_out, portg_oe, portg_pullup_on,
  output logic [2:0] portf_in,
  output logic [2:1] portg_in
);
  logic t = 1'b0;
  always @(posedge clk) t <= ~t;
  always_comb begin
    for (int i = 0; i < 3; i++)
      portf_in[i] = portf_oe[i] ? portf_out[i] : fd[i] ? fv[i] : (i == 2) || t;
    for (int i = 1; i < 3; i++)
      portg_in[i] = portg_oe[i] ? portg_out[i] : portg_pullup_on[i] || t;
  end
endmodule

// ### verification/test_two_port_pin_io.sv
`timescale 1ns/100ps
module test_two_port_pin_io;
  logic clk = 0, rst_n = 0, read = 0, write = 0, readmodwrite_access = 0, stop_or_watch = 0;
  logic [3:0] address = 0, pe = 0, pv = 0;
  logic [31:0] writedata = 0;
  logic [2:0] fd = 0, fv = 0;
  logic [7:0] q;
  wire [31:0] readdata;
  wire waitrequest, ext_reset_in_n;
  wire [2:0] portf_in, portf_out, portf_oe, portf_internal_in;
  wire [2:1] portg_in, portg_out, portg_oe, portg_pullup_on, portg_internal_in;
  int miscompares = 0, tests_run = 0;
  tpio_top dut (.*, .clk_en(1'b1), .por_active(1'b0), .buzzer_output(pv[0]),
    .buzzer_oe(pe[0]), .compare_ch0_output(pv[1]), .compare_ch0_oe(pe[1]),
    .pulse_gen_output(pv[2]), .pulse_gen_oe(pe[2]), .compare_ch1_output(pv[3]),
    .compare_ch1_oe(pe[3]));
  tpio_board brd (.*);
  task automatic chk(input [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Waitrequest is taken 1 ns after each edge, and the request holds to the next edge.
  task automatic bus(input [3:0] a, input w, m, input [7:0] d);
    int n;
    logic wt;
    n = 0;
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    readmodwrite_access <= m;
    writedata <= {24'h0, d};
    do begin
      #1;
      wt = waitrequest;
      q = readdata[7:0];
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 40);
    write <= 0;
    read <= 0;
    if (wt !== 1'b0) begin
      miscompares++;
      $display("ERROR %0t: bus timeout", $time);
      finish_test;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d); bus(a, 1, 0, d); endtask
  task rd(input [3:0] a, input m, input [7:0] e); bus(a, 0, m, 8'h00); chk(q, e); endtask
  task st; repeat (2) @(posedge clk); #1; endtask
  task t_reset;
    chk({portf_oe, portf_out, portg_oe}, 8'h00);
    rd(4'h1, 0, 8'h00);
    rd(4'h3, 0, 8'h00);
    wr(4'h7, 8'h5a);
    rd(4'h7, 0, 8'h00);
    rd(4'h6, 0, 8'h01);
  endtask
  task t_fout;
    wr(4'h5, 8'h01);
    wr(4'h1, 8'h07);
    wr(4'h0, 8'h05);
    st;
    chk({portf_oe, portf_out, portg_oe}, 8'h64);
    rd(4'h0, 0, 8'h05);
    wr(4'h0, 8'hfa);
    rd(4'h0, 0, 8'h02);
    st;
    chk({portf_oe, portf_out, portg_oe}, 8'he8);
  endtask
  task t_fin;
    fd <= 3'h7;
    fv <= 3'h6;
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h05);
    st;
    chk({5'h0, portf_oe}, 8'h00);
    rd(4'h0, 0, 8'h06);
    rd(4'h0, 1, 8'h05);
    fd <= 3'h0;
  endtask
  task t_gpull;
    wr(4'h5, 8'h03);
    wr(4'h4, 8'h06);
    st;
    chk({6'h0, portg_pullup_on}, 8'h03);
    wr(4'h3, 8'h06);
    wr(4'h2, 8'hf9);
    st;
    chk({2'h0, portg_oe, portg_out, portg_pullup_on}, 8'h30);
    wr(4'h2, 8'hff);
    rd(4'h2, 0, 8'h06);
    st;
    chk({2'h0, portg_oe, portg_out, portg_pullup_on}, 8'h3f);
  endtask
  task t_periph;
    pe <= 4'hf;
    pv <= 4'ha;
    st;
    chk({4'h0, portg_oe, portg_out}, 8'h0c);
    rd(4'h2, 0, 8'h00);
    rd(4'h2, 1, 8'h06);
    pv <= 4'h5;
    st;
    chk({4'h0, portg_oe, portg_out}, 8'h0f);
    pe <= 4'h0;
    pv <= 4'h0;
  endtask
  task t_standby;
    wr(4'h1, 8'h07);
    wr(4'h5, 8'h0b);
    stop_or_watch <= 1;
    st;
    chk({portf_oe, portf_internal_in, portg_oe}, 8'h00);
    stop_or_watch <= 0;
    wr(4'h5, 8'h03);
    stop_or_watch <= 1;
    st;
    chk({portf_oe, portf_out, portg_oe}, 8'h67);
    stop_or_watch <= 0;
  endtask
  task t_own;
    wr(4'h5, 8'h04);
    fd <= 3'h4;
    fv <= 3'h0;
    st;
    chk({portf_oe, portg_oe, 3'h0}, 8'h00);
    chk({7'h0, ext_reset_in_n}, 8'h00);
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    t_reset;
    t_fout;
    t_fin;
    t_gpull;
    t_periph;
    t_standby;
    t_own;
    finish_test;
  end
endmodule
